//--- ccf_pkg.sv
/*
 Shared constants and carrier types for the codec calibration and
 format control block. Assumes a 32-bit Avalon-MM register bus.
*/
package ccf_pkg;
  // Register byte offsets
  localparam logic [5:0] ADDR_INDEX = 6'h00;
  localparam logic [5:0] ADDR_RATE_FMT = 6'h04;
  localparam logic [5:0] ADDR_IF_CFG = 6'h08;
  localparam logic [5:0] ADDR_OVS = 6'h0c;
  localparam logic [5:0] ADDR_ERR_INIT = 6'h10;
  localparam logic [5:0] ADDR_ALT_FEAT = 6'h14;
  localparam logic [5:0] ADDR_ALT_RATE = 6'h18;
  localparam logic [5:0] ADDR_CAP_FMT = 6'h1c;
  // Field positions
  localparam int MCE_BIT = 6;
  localparam int PEN_BIT = 0;
  localparam int CEN_BIT = 1;
  localparam int CALSEL_LSB = 3;
  localparam int ACI_BIT = 5;
  localparam int EXT_BIT = 0;
  localparam int PUNLOCK_BIT = 4;
  localparam int CUNLOCK_BIT = 5;
  localparam int ARE_BIT = 0;
  // Values
  localparam logic [7:0] BUSY_READ = 8'h80;
  localparam logic [7:0] RATE_FMT_RST = 8'h00;
  localparam logic [7:0] IF_CFG_RST = 8'h18;
  localparam logic [1:0] CAL_NONE = 2'h0;
  localparam logic [1:0] CAL_CONV = 2'h1;
  localparam logic [1:0] CAL_DAC = 2'h2;
  localparam logic [1:0] CAL_FULL = 2'h3;
  // Format codes, upper nibble bits 7:5
  localparam logic [2:0] FMT_U8 = 3'h0;
  localparam logic [2:0] FMT_ULAW = 3'h1;
  localparam logic [2:0] FMT_S16LE = 3'h2;
  localparam logic [2:0] FMT_ALAW = 3'h3;
  localparam logic [2:0] FMT_ADPCM = 3'h5;
  localparam logic [2:0] FMT_S16BE = 3'h6;
  // Midscale codes
  localparam logic [15:0] MID_S16 = 16'h0000;
  localparam logic [15:0] MID_U8 = 16'h0080;
  // Calibration lengths in sample periods
  localparam logic [7:0] NONE_SWITCH_SP = 8'h28;
  localparam logic [7:0] MIXER_SP = 8'h20;
  localparam logic [7:0] ADC_SP = 8'h40;
  localparam logic [7:0] DAC_SP = 8'h48;
  localparam logic [7:0] FILT_SP = 8'h28;
  // Clock cycles
  localparam int RESYNC_CYC = 64;
  localparam int SAMPLE_BASE_CYC = 2048;

  typedef struct packed {
    logic stereo;
    logic wide;
    logic is_signed;
    logic big_endian;
    logic mulaw;
    logic alaw;
    logic adpcm;
  } ccf_fmt_t;

  typedef struct packed {
    logic alternate;
    logic [1:0] oversample;
    logic [6:0] fine;
    logic [3:0] std_rate;
  } ccf_rate_t;

  typedef enum {CAL_IDLE, CAL_MIXER, CAL_ADC, CAL_DACS, CAL_FILT, CAL_SETTLE}
    ccf_cal_state_t;
endpackage

//--- ccf_control.sv
/*
 Calibration sequencer, resync busy window, register gating and format
 decode of the codec control block, as an Avalon-MM slave.
 Assumes a single 100 MHz clock and inputs synchronous to it.
*/
// Chosen here: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/1ps
// Overview of operation
// - Calibration starts when mode change enable falls from 1 to 0.
// - Calibration-in-progress bit is high for the whole calibration.
// - Enabled transfers wait until calibration has finished.
// - Select 00 none, 01 converters, 10 DAC filters, 11 full.
// - None mode never mutes; 40 periods after switch, then zero.
// - None mode leaves the FIFOs alone.
// - Converter mode mutes DACs, does ADCs then DACs, 136 periods.
// - DAC mode mutes, clears playback filters, unmutes, 40 periods.
// - Full mode mutes all, mixer, ADCs, DACs, 168 periods.
// - Full calibration runs at reset and on leaving power-down.
// - During clock resync writes are dropped and reads give 80h.
// - Clock, format and config writes need mode change enable, except the two config enable bits.
// - Alternate rate enable replaces the four low rate bits.
// - Alternate rate bits change at any time.
// - Format unlock in extended mode clears FIFO, opens upper bits.
// - Basic mode one format for both; extended has capture format.
// - Left sample always precedes right sample.
// - Basic formats four; extended adds ADPCM and big endian.
// - Signed 16-bit: two's complement, center zero.
// - Unsigned 8-bit: center 128.
module ccf_control #(
  parameter int RESYNC_CYCLES = ccf_pkg::RESYNC_CYC,
  parameter int SAMPLE_BASE = ccf_pkg::SAMPLE_BASE_CYC
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic power_down,
  input wire logic word_strobe,
  output logic sample_tick,
  output logic slot_left,
  output logic dac_mute,
  output logic mixer_mute,
  output logic mixer_cal,
  output logic adc_cal,
  output logic dac_cal,
  output logic dac_filter_clear,
  output logic play_fifo_clear,
  output logic cap_fifo_clear,
  output logic playback_run,
  output logic capture_run,
  output ccf_pkg::ccf_fmt_t play_fmt,
  output ccf_pkg::ccf_fmt_t cap_fmt,
  output ccf_pkg::ccf_rate_t rate_sel,
  output logic [15:0] play_silence
);
  logic ack_reg;
  logic mce_reg;
  logic mce_prev_reg;
  logic [7:0] rate_fmt_reg;
  logic [7:0] if_cfg_reg;
  logic [1:0] ovs_reg;
  logic [7:0] alt_feat_reg;
  logic [7:0] alt_rate_reg;
  logic [7:0] cap_fmt_reg;
  logic [$clog2(RESYNC_CYCLES+1)-1:0] resync_reg;
  logic [12:0] div_reg;
  ccf_pkg::ccf_cal_state_t cal_reg;
  logic [7:0] cnt_reg;
  logic full_reg;
  logic last_none_reg;
  logic auto_reg;
  logic pd_prev_reg;
  logic do_wr;
  logic resync;
  logic cal_busy;
  logic ext;
  logic start;
  logic [31:0] rd_next;
  logic [12:0] period;

  assign ext = alt_feat_reg[ccf_pkg::EXT_BIT];
  assign resync = resync_reg != '0;
  assign cal_busy = cal_reg != ccf_pkg::CAL_IDLE;

  //////////////////////////////////////////////////////////////////////
  // Bus handshake: one wait cycle, then answer
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;
  assign do_wr = avs_write & ack_reg & ~resync;

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= (avs_read | avs_write) & ~ack_reg;
    end
  end

  // Read mux; unmapped offsets read zero
  always_comb begin
    rd_next = 32'h0000_0000;
    case (avs_address)
      ccf_pkg::ADDR_INDEX: rd_next[ccf_pkg::MCE_BIT] = mce_reg;
      ccf_pkg::ADDR_RATE_FMT: rd_next[7:0] = rate_fmt_reg;
      ccf_pkg::ADDR_IF_CFG: rd_next[7:0] = if_cfg_reg;
      ccf_pkg::ADDR_OVS: rd_next[1:0] = ovs_reg;
      ccf_pkg::ADDR_ERR_INIT: rd_next[ccf_pkg::ACI_BIT] = cal_busy;
      ccf_pkg::ADDR_ALT_FEAT: rd_next[7:0] = alt_feat_reg;
      ccf_pkg::ADDR_ALT_RATE: rd_next[7:0] = alt_rate_reg;
      ccf_pkg::ADDR_CAP_FMT: rd_next[7:0] = cap_fmt_reg;
      default: rd_next = 32'h0000_0000;
    endcase
    if (resync) begin
      rd_next = {24'h00_0000, ccf_pkg::BUSY_READ};
    end
  end

  // Read data captured in the wait cycle, stands at the answer edge
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read & ~ack_reg) begin
      avs_readdata <= rd_next;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Mode change enable and its falling edge
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      mce_reg <= 1'b0;
      mce_prev_reg <= 1'b0;
    end else begin
      mce_prev_reg <= mce_reg;
      if (do_wr && avs_address == ccf_pkg::ADDR_INDEX) begin
        mce_reg <= avs_writedata[ccf_pkg::MCE_BIT];
      end
    end
  end

  // Rate and playback format: low nibble only under mode change
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      rate_fmt_reg <= ccf_pkg::RATE_FMT_RST;
    end else if (do_wr && avs_address == ccf_pkg::ADDR_RATE_FMT) begin
      if (mce_reg) begin
        rate_fmt_reg[3:0] <= avs_writedata[3:0];
      end
      if (mce_reg || (ext && alt_feat_reg[ccf_pkg::PUNLOCK_BIT])) begin
        rate_fmt_reg[7:4] <= avs_writedata[7:4];
      end
    end
  end

  // Capture format, own unlock in extended mode
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      cap_fmt_reg <= ccf_pkg::RATE_FMT_RST;
    end else if (do_wr && avs_address == ccf_pkg::ADDR_CAP_FMT) begin
      if (mce_reg || (ext && alt_feat_reg[ccf_pkg::CUNLOCK_BIT])) begin
        cap_fmt_reg[7:4] <= avs_writedata[7:4];
      end
    end
  end

  // Interface config; enables are writable on the fly
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      if_cfg_reg <= ccf_pkg::IF_CFG_RST;
    end else if (do_wr && avs_address == ccf_pkg::ADDR_IF_CFG) begin
      if (mce_reg) begin
        if_cfg_reg <= avs_writedata[7:0];
      end else begin
        if_cfg_reg[ccf_pkg::PEN_BIT] <= avs_writedata[ccf_pkg::PEN_BIT];
        if_cfg_reg[ccf_pkg::CEN_BIT] <= avs_writedata[ccf_pkg::CEN_BIT];
      end
    end
  end

  // Alternate rate path needs no mode change cycle
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      ovs_reg <= 2'h0;
      alt_rate_reg <= 8'h00;
      alt_feat_reg <= 8'h00;
    end else if (do_wr) begin
      if (avs_address == ccf_pkg::ADDR_OVS) begin
        ovs_reg <= avs_writedata[1:0];
      end
      if (avs_address == ccf_pkg::ADDR_ALT_RATE) begin
        alt_rate_reg <= avs_writedata[7:0];
      end
      if (avs_address == ccf_pkg::ADDR_ALT_FEAT) begin
        alt_feat_reg <= avs_writedata[7:0];
      end
    end
  end

  // FIFO clear pulses on a rising unlock bit, extended mode only
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      play_fifo_clear <= 1'b0;
      cap_fifo_clear <= 1'b0;
    end else begin
      play_fifo_clear <= do_wr && avs_address == ccf_pkg::ADDR_ALT_FEAT
        && avs_writedata[ccf_pkg::EXT_BIT]
        && avs_writedata[ccf_pkg::PUNLOCK_BIT]
        && !alt_feat_reg[ccf_pkg::PUNLOCK_BIT];
      cap_fifo_clear <= do_wr && avs_address == ccf_pkg::ADDR_ALT_FEAT
        && avs_writedata[ccf_pkg::EXT_BIT]
        && avs_writedata[ccf_pkg::CUNLOCK_BIT]
        && !alt_feat_reg[ccf_pkg::CUNLOCK_BIT];
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Resync window after a clock bit change; host polls it out
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      resync_reg <= '0;
    end else if (do_wr && mce_reg && avs_address == ccf_pkg::ADDR_RATE_FMT
                 && avs_writedata[3:0] != rate_fmt_reg[3:0]) begin
      resync_reg <= RESYNC_CYCLES[$bits(resync_reg)-1:0];
    end else if (resync) begin
      resync_reg <= resync_reg - 1'b1;
    end
  end

  // Selected rate; alternate path hides the low rate bits
  assign rate_sel.alternate = alt_rate_reg[ccf_pkg::ARE_BIT];
  assign rate_sel.oversample = ovs_reg;
  assign rate_sel.fine = alt_rate_reg[7:1];
  assign rate_sel.std_rate = rate_sel.alternate ? 4'h0 : rate_fmt_reg[3:0];

  // Sample pacing; period grows with the rate code, a stand-in scale
  assign period = rate_sel.alternate
    ? 13'(SAMPLE_BASE) + {4'h0, ovs_reg, alt_rate_reg[7:1]}
    : 13'(SAMPLE_BASE) + {5'h00, rate_fmt_reg[3:0], 4'h0};

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      div_reg <= 13'h0000;
      sample_tick <= 1'b0;
    end else begin
      sample_tick <= div_reg >= period;
      div_reg <= (div_reg >= period) ? 13'h0000 : div_reg + 13'h0001;
    end
  end

  // Left slot first in each frame, right after the next word
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      slot_left <= 1'b1;
    end else if (sample_tick) begin
      slot_left <= 1'b1;
    end else if (word_strobe) begin
      slot_left <= ~slot_left;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Automatic full calibration request; the new request wins the clear
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      auto_reg <= 1'b1;
      pd_prev_reg <= 1'b0;
    end else begin
      pd_prev_reg <= power_down;
      if (pd_prev_reg && !power_down) begin
        auto_reg <= 1'b1;
      end else if (!cal_busy && !power_down) begin
        auto_reg <= 1'b0;
      end
    end
  end

  assign start = !cal_busy && !power_down
    && (auto_reg || (mce_prev_reg && !mce_reg));

  // Calibration sequencer, counted in sample periods
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      cal_reg <= ccf_pkg::CAL_IDLE;
      cnt_reg <= 8'h00;
      full_reg <= 1'b0;
      last_none_reg <= 1'b0;
    end else begin
      case (cal_reg)
        ccf_pkg::CAL_IDLE: begin
          if (start && auto_reg) begin
            full_reg <= 1'b1;
            last_none_reg <= 1'b0;
            cal_reg <= ccf_pkg::CAL_MIXER;
            cnt_reg <= ccf_pkg::MIXER_SP;
          end else if (start) begin
            full_reg <= if_cfg_reg[4:3] == ccf_pkg::CAL_FULL;
            last_none_reg <= if_cfg_reg[4:3] == ccf_pkg::CAL_NONE;
            case (if_cfg_reg[4:3])
              ccf_pkg::CAL_NONE: begin
                if (!last_none_reg) begin
                  cal_reg <= ccf_pkg::CAL_SETTLE;
                  cnt_reg <= ccf_pkg::NONE_SWITCH_SP;
                end
              end
              ccf_pkg::CAL_CONV: begin
                cal_reg <= ccf_pkg::CAL_ADC;
                cnt_reg <= ccf_pkg::ADC_SP;
              end
              ccf_pkg::CAL_DAC: begin
                cal_reg <= ccf_pkg::CAL_FILT;
                cnt_reg <= ccf_pkg::FILT_SP;
              end
              default: begin
                cal_reg <= ccf_pkg::CAL_MIXER;
                cnt_reg <= ccf_pkg::MIXER_SP;
              end
            endcase
          end
        end
        default: begin
          if (sample_tick) begin
            if (cnt_reg != 8'h01) begin
              cnt_reg <= cnt_reg - 8'h01;
            end else begin
              case (cal_reg)
                ccf_pkg::CAL_MIXER: begin
                  cal_reg <= ccf_pkg::CAL_ADC;
                  cnt_reg <= ccf_pkg::ADC_SP;
                end
                ccf_pkg::CAL_ADC: begin
                  cal_reg <= ccf_pkg::CAL_DACS;
                  cnt_reg <= ccf_pkg::DAC_SP;
                end
                default: begin
                  cal_reg <= ccf_pkg::CAL_IDLE;
                  full_reg <= 1'b0;
                end
              endcase
            end
          end
        end
      endcase
    end
  end

  // Mutes and phase flags; no-calibration settle leaves outputs live
  assign dac_mute = cal_busy && cal_reg != ccf_pkg::CAL_SETTLE;
  assign mixer_mute = cal_busy && full_reg;
  assign mixer_cal = cal_reg == ccf_pkg::CAL_MIXER;
  assign adc_cal = cal_reg == ccf_pkg::CAL_ADC;
  assign dac_cal = cal_reg == ccf_pkg::CAL_DACS;
  assign dac_filter_clear = cal_reg == ccf_pkg::CAL_FILT;

  // Enabled transfers are held off while calibrating
  assign playback_run = if_cfg_reg[ccf_pkg::PEN_BIT] && !cal_busy;
  assign capture_run = if_cfg_reg[ccf_pkg::CEN_BIT] && !cal_busy;

  //////////////////////////////////////////////////////////////////////
  // Format decode; extended-only codes fall back to 8-bit unsigned
  function automatic ccf_pkg::ccf_fmt_t decode(input logic [3:0] c,
                                               input logic x);
    ccf_pkg::ccf_fmt_t f;
    f = '0;
    f.stereo = c[0];
    case (c[3:1])
      ccf_pkg::FMT_ULAW: f.mulaw = 1'b1;
      ccf_pkg::FMT_ALAW: f.alaw = 1'b1;
      ccf_pkg::FMT_S16LE: begin
        f.wide = 1'b1;
        f.is_signed = 1'b1;
      end
      ccf_pkg::FMT_ADPCM: f.adpcm = x;
      ccf_pkg::FMT_S16BE: begin
        f.wide = x;
        f.is_signed = x;
        f.big_endian = x;
      end
      default: f.wide = 1'b0;
    endcase
    return f;
  endfunction

  // Basic mode shares one format; extended splits capture off
  assign play_fmt = decode(rate_fmt_reg[7:4], ext);
  assign cap_fmt = ext ? decode(cap_fmt_reg[7:4], 1'b1)
                       : decode(rate_fmt_reg[7:4], 1'b0);

  // Silence code for linear playback formats
  assign play_silence = play_fmt.is_signed ? ccf_pkg::MID_S16
                                           : ccf_pkg::MID_U8;
endmodule

//--- ccf_control_chk.sv
/*
 Port-level assertions for the codec calibration and format control block.
 Assumes one clock domain; bound onto every ccf_control instance.
*/
`timescale 1ns/1ps
module ccf_control_chk (
  input logic mclk,
  input logic sys_rst,
  input logic avs_read,
  input logic avs_write,
  input logic avs_waitrequest,
  input logic word_strobe,
  input logic sample_tick,
  input logic slot_left,
  input logic dac_mute,
  input logic mixer_mute,
  input logic mixer_cal,
  input logic adc_cal,
  input logic dac_cal,
  input logic dac_filter_clear,
  input logic play_fifo_clear,
  input logic playback_run,
  input logic capture_run,
  input ccf_pkg::ccf_fmt_t play_fmt,
  input ccf_pkg::ccf_rate_t rate_sel,
  input logic [15:0] play_silence
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  //////////////////////////////////////////////////////////////////////////////
  // Calibration phases: mute ordering and transfer hold-off
  a_cal_blocks_run: assert property ((dac_mute||mixer_mute) |-> !playback_run&&!capture_run)
    else $error("transfer running during calibration");
  a_phase_is_muted: assert property ((adc_cal || dac_cal || dac_filter_clear) |-> dac_mute)
    else $error("converter phase without dac mute");
  a_full_mutes_all: assert property (mixer_cal |-> mixer_mute && dac_mute)
    else $error("mixer phase without full mute");
  a_filter_alone: assert property (dac_filter_clear |-> !adc_cal && !mixer_mute)
    else $error("filter clear touched adc or mixer");
  a_adc_then_dac: assert property ($fell(adc_cal) && dac_mute |-> dac_cal)
    else $error("dac phase does not follow adc phase");
  a_mixer_then_adc: assert property ($fell(mixer_cal) && mixer_mute |-> adc_cal)
    else $error("adc phase does not follow mixer phase");
  //////////////////////////////////////////////////////////////////////////////
  // Bus, fifo, stream order and format outputs
  a_one_wait: assert property ((avs_read||avs_write)&&avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer not after one wait");
  a_fifo_pulse: assert property (play_fifo_clear |=> !play_fifo_clear)
    else $error("fifo clear longer than one cycle");
  a_left_first: assert property (sample_tick |=> slot_left)
    else $error("sample does not start on left slot");
  a_slot_swap: assert property (word_strobe&&!sample_tick |=> slot_left==!$past(slot_left))
    else $error("slot did not alternate per word");
  a_silence_code: assert property (!play_fmt.adpcm |->
    play_silence == (play_fmt.wide ? ccf_pkg::MID_S16 : ccf_pkg::MID_U8))
    else $error("silence code wrong for format");
  a_alt_std_zero: assert property (rate_sel.alternate |-> rate_sel.std_rate == 4'h0)
    else $error("standard rate not ignored");
  // Main scenarios reached
  c_mixer_cal: cover property (mixer_cal);
  c_filter_clear: cover property (dac_filter_clear);
  c_fifo_clear: cover property (play_fifo_clear);
endmodule

bind ccf_control ccf_control_chk chk (.mclk, .sys_rst, .avs_read, .avs_write, .avs_waitrequest,
  .word_strobe, .sample_tick, .slot_left, .dac_mute, .mixer_mute, .mixer_cal, .adc_cal,
  .dac_cal, .dac_filter_clear, .play_fifo_clear, .playback_run, .capture_run, .play_fmt,
  .rate_sel, .play_silence);

//--- ccf_word_mover.sv
/*
 Far-side audio data mover: moves one stereo pair per sample period.
 Assumes sample_tick pulses are at least four cycles apart.
*/
`timescale 1ns/1ps
module ccf_word_mover (
  input logic mclk,
  input logic sys_rst,
  input logic sample_tick,
  input logic run,
  output logic word_strobe
);
  logic [2:0] step_reg;
  // Left word one cycle after the tick, right word two later; idle unless run
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      step_reg <= 3'h0;
    end else begin
      step_reg <= {step_reg[1:0], sample_tick & run};
    end
  end
  assign word_strobe = step_reg[0] | step_reg[2];
endmodule

//--- ccf_control_tb.sv
/*
 Self-checking bench for the codec control block: calibration table, then
 resync, gating, power-down, formats, unlock and alternate rate.
 Assumes the design package is compiled first.
*/
`timescale 1ns/1ps
`define CCF_CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin failures++; \
  $display("wrong value %s expected %h seen %h", nm, ex, got); end end
module ccf_control_tb;
  logic mclk, sys_rst, avs_read, avs_write, power_down, word_strobe, avs_waitrequest;
  logic [5:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic sample_tick, slot_left, dac_mute, mixer_mute, mixer_cal, adc_cal, dac_cal;
  logic dac_filter_clear, play_fifo_clear, cap_fifo_clear, playback_run, capture_run, pen_on;
  ccf_pkg::ccf_fmt_t play_fmt, cap_fmt;
  ccf_pkg::ccf_rate_t rate_sel;
  logic [15:0] play_silence;
  logic [7:0] rdat;
  logic [2:0] fcodes[5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h6};
  int failures = 0, checks_done = 0, cycles = 0, mute_t = 0, mix_t = 0, hold_t = 0, pfc_t = 0;
  typedef struct {logic [1:0] cal; int hold; int mute; int mix;} ccf_row_t;
  ccf_row_t rows[5] = '{'{2'h3, 8'ha8, 8'ha8, 8'ha8}, '{2'h1, 8'h88, 8'h88, 8'h00},
    '{2'h0, 8'h28, 8'h00, 8'h00}, '{2'h0, 8'h00, 8'h00, 8'h00}, '{2'h2, 8'h28, 8'h28, 8'h00}};

  ccf_control #(.RESYNC_CYCLES(8), .SAMPLE_BASE(8)) dut (.mclk, .sys_rst, .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .power_down,
    .word_strobe, .sample_tick, .slot_left, .dac_mute, .mixer_mute, .mixer_cal, .adc_cal,
    .dac_cal, .dac_filter_clear, .play_fifo_clear, .cap_fifo_clear, .playback_run,
    .capture_run, .play_fmt, .cap_fmt, .rate_sel, .play_silence);
  ccf_word_mover mover (.mclk, .sys_rst, .sample_tick, .run(playback_run | capture_run),
    .word_strobe);

  //////////////////////////////////////////////////////////////////////////////
  // Clock, hang guard, per-period event counters and per-cycle fifo clear counter
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cycles++;
    if (play_fifo_clear === 1'b1) pfc_t++;
    if (cap_fifo_clear === 1'b1) pfc_t += 2;
    if (sample_tick === 1'b1) begin
      mute_t += (dac_mute === 1'b1);
      mix_t += (mixer_mute === 1'b1);
      hold_t += (pen_on && playback_run === 1'b0);
    end
    if (cycles == 32'h7530) begin
      failures++;
      tally_and_finish();
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Helpers
  task automatic tally_and_finish();
    if (failures == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // One bus cycle; request held until waitrequest is low at a rising edge
  task automatic bus(input logic we, input logic [5:0] a, input logic [7:0] d);
    @(posedge mclk);
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_write <= we;
    avs_read <= !we;
    do begin
      @(posedge mclk);
    end while (avs_waitrequest !== 1'b0);
    rdat = avs_readdata[7:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  // Cleared away from the counting edge to avoid a race
  task automatic clr();
    @(negedge mclk);
    mute_t = 0;
    mix_t = 0;
    hold_t = 0;
    pfc_t = 0;
  endtask
  task automatic wait_cal();
    bus(1'b0, ccf_pkg::ADDR_ERR_INIT, 8'h00);
    while (rdat[ccf_pkg::ACI_BIT] !== 1'b0) begin
      bus(1'b0, ccf_pkg::ADDR_ERR_INIT, 8'h00);
    end
  endtask
  function automatic ccf_pkg::ccf_fmt_t fexp(input logic [2:0] c, input logic st, input logic ext);
    ccf_pkg::ccf_fmt_t f;
    logic [2:0] k;
    k = (!ext && c > 3'h3) ? ccf_pkg::FMT_U8 : c;
    f = '0;
    f.stereo = st;
    f.wide = (k == ccf_pkg::FMT_S16LE) || (k == ccf_pkg::FMT_S16BE);
    f.is_signed = f.wide;
    f.big_endian = (k == ccf_pkg::FMT_S16BE);
    f.mulaw = (k == ccf_pkg::FMT_ULAW);
    f.alaw = (k == ccf_pkg::FMT_ALAW);
    f.adpcm = (k == ccf_pkg::FMT_ADPCM);
    return f;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    sys_rst = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 6'h00;
    avs_writedata = 32'h0;
    power_down = 1'b0;
    pen_on = 1'b0;
    repeat (8) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    @(negedge mclk);
    `CCF_CHK("mixer_mute", 1'b1, mixer_mute)
    bus(1'b0, ccf_pkg::ADDR_ERR_INIT, 8'h00);
    `CCF_CHK("status", 8'h20, rdat)
    bus(1'b0, ccf_pkg::ADDR_IF_CFG, 8'h00);
    `CCF_CHK("if_cfg", ccf_pkg::IF_CFG_RST, rdat)
    bus(1'b1, 6'h3c, 8'hff);
    bus(1'b0, 6'h3c, 8'h00);
    `CCF_CHK("unmapped", 8'h00, rdat)
    wait_cal();
    `CCF_CHK("auto mute", 168, mute_t)
    `CCF_CHK("auto mixer", 168, mix_t)
    // Calibration table, enable dance as the host is asked to do it
    pen_on = 1'b1;
    foreach (rows[i]) begin
      bus(1'b1, ccf_pkg::ADDR_INDEX, 8'h40);
      bus(1'b1, ccf_pkg::ADDR_IF_CFG, {3'h0, rows[i].cal, 3'h1});
      clr();
      bus(1'b1, ccf_pkg::ADDR_INDEX, 8'h00);
      wait_cal();
      `CCF_CHK("hold ticks", rows[i].hold, hold_t)
      `CCF_CHK("mute ticks", rows[i].mute, mute_t)
      `CCF_CHK("mixer ticks", rows[i].mix, mix_t)
    end
    // Rate change opens a busy window; dropped write, busy reads
    bus(1'b1, ccf_pkg::ADDR_INDEX, 8'h40);
    bus(1'b1, ccf_pkg::ADDR_RATE_FMT, 8'h01);
    bus(1'b1, ccf_pkg::ADDR_OVS, 8'h03);
    bus(1'b0, ccf_pkg::ADDR_INDEX, 8'h00);
    `CCF_CHK("busy read", ccf_pkg::BUSY_READ, rdat)
    for (int n = 0; n < 100 && rdat === ccf_pkg::BUSY_READ; n++) bus(1'b0, 6'h00, 8'h00);
    `CCF_CHK("index", 8'h40, rdat)
    bus(1'b0, ccf_pkg::ADDR_OVS, 8'h00);
    `CCF_CHK("dropped write", 8'h00, rdat)
    bus(1'b1, ccf_pkg::ADDR_INDEX, 8'h00);
    wait_cal();
    // Gated writes without mode change enable
    bus(1'b1, ccf_pkg::ADDR_IF_CFG, 8'h02);
    bus(1'b0, ccf_pkg::ADDR_IF_CFG, 8'h00);
    `CCF_CHK("if_cfg gated", 8'h12, rdat)
    `CCF_CHK("capture_run", 2'b10, {capture_run, playback_run})
    bus(1'b1, ccf_pkg::ADDR_RATE_FMT, 8'hf7);
    bus(1'b0, ccf_pkg::ADDR_RATE_FMT, 8'h00);
    `CCF_CHK("rate gated", 8'h01, rdat)
    // Leaving power-down runs a full calibration
    @(posedge mclk);
    power_down <= 1'b1;
    repeat (4) @(posedge mclk);
    clr();
    @(posedge mclk);
    power_down <= 1'b0;
    repeat (3) @(posedge mclk);
    wait_cal();
    `CCF_CHK("pd mixer", 168, mix_t)
    // Basic formats drive both directions
    bus(1'b1, ccf_pkg::ADDR_INDEX, 8'h40);
    foreach (fcodes[i]) begin
      bus(1'b1, ccf_pkg::ADDR_RATE_FMT, {fcodes[i], 1'b1, 4'h1});
      @(negedge mclk);
      `CCF_CHK("play_fmt", fexp(fcodes[i], 1'b1, 1'b0), play_fmt)
      `CCF_CHK("cap_fmt", fexp(fcodes[i], 1'b1, 1'b0), cap_fmt)
      `CCF_CHK("silence", {8'h00, fcodes[i] != 3'h2, 7'h00}, play_silence)
    end
    // Extended mode: separate capture format, extra codes
    bus(1'b1, ccf_pkg::ADDR_ALT_FEAT, 8'h01);
    bus(1'b1, ccf_pkg::ADDR_CAP_FMT, {ccf_pkg::FMT_S16LE, 1'b0, 4'h0});
    bus(1'b1, ccf_pkg::ADDR_RATE_FMT, {ccf_pkg::FMT_S16BE, 1'b1, 4'h1});
    @(negedge mclk);
    `CCF_CHK("cap ext", fexp(3'h2, 1'b0, 1'b1), cap_fmt)
    `CCF_CHK("play be", fexp(3'h6, 1'b1, 1'b1), play_fmt)
    `CCF_CHK("silence s16", 16'h0000, play_silence)
    bus(1'b1, ccf_pkg::ADDR_RATE_FMT, {ccf_pkg::FMT_ADPCM, 1'b1, 4'h1});
    @(negedge mclk);
    `CCF_CHK("adpcm", 1'b1, play_fmt.adpcm)
    bus(1'b1, ccf_pkg::ADDR_INDEX, 8'h00);
    wait_cal();
    // Unlock opens the playback format without a calibration
    bus(1'b1, ccf_pkg::ADDR_RATE_FMT, 8'h21);
    bus(1'b0, ccf_pkg::ADDR_RATE_FMT, 8'h00);
    `CCF_CHK("locked fmt", 8'hb1, rdat)
    clr();
    bus(1'b1, ccf_pkg::ADDR_ALT_FEAT, 8'h31);
    bus(1'b1, ccf_pkg::ADDR_RATE_FMT, 8'h21);
    bus(1'b0, ccf_pkg::ADDR_RATE_FMT, 8'h00);
    `CCF_CHK("unlocked fmt", 8'h21, rdat)
    `CCF_CHK("fifo clears", 3, pfc_t)
    bus(1'b0, ccf_pkg::ADDR_ERR_INIT, 8'h00);
    `CCF_CHK("no cal", 1'b0, rdat[ccf_pkg::ACI_BIT])
    // Alternate rate path, no mode change needed
    bus(1'b1, ccf_pkg::ADDR_ALT_RATE, 8'h0b);
    bus(1'b1, ccf_pkg::ADDR_OVS, 8'h01);
    @(negedge mclk);
    `CCF_CHK("alt", 1'b1, rate_sel.alternate)
    `CCF_CHK("std", 4'h0, rate_sel.std_rate)
    `CCF_CHK("fine", 7'h05, rate_sel.fine)
    `CCF_CHK("ovs", 2'h1, rate_sel.oversample)
    tally_and_finish();
  end
endmodule
